// [inc/isf_pkg.sv]
// Package: constants and carrier types of the in-band status message framer
`default_nettype none
package isf_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_PERIOD = 4'h4;
  localparam logic [3:0] OFS_RETRY  = 4'h8;
  localparam logic [3:0] OFS_INFO   = 4'hc;
  // Reset values
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'h0000;
  localparam logic [15:0] RST_RETRY  = 16'h0064;
  // Status fields that may be sent, everything else is sent as zero
  localparam logic [15:0] STAT_MASK  = 16'h27bf;
  // Symbols and control bytes
  localparam logic [7:0] K28_1      = 8'h3c;
  localparam logic [7:0] CTL_STATUS = 8'h80;
  localparam logic [7:0] CTL_ACK    = 8'hc0;
  localparam logic [7:0] CTL_RESP   = 8'h40;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] RSV_BYTE   = 8'h00;
  // Field positions
  localparam int CTL_WR_BIT = 5;
  localparam int INFO_ACK_BIT = 31;
  localparam int INFO_ERR_LSB = 16;
  // Timing: timeout registers count microseconds
  localparam int CLK_NS = 20;
  localparam int US_NS = 1000;
  localparam logic [5:0] CYC_PER_US = 6'((US_NS + CLK_NS - 1) / CLK_NS);
  // Index of the last frame symbol, frames are six symbols long
  localparam logic [2:0] LAST_IDX = 3'h5;

  // One link symbol: control flag and byte
  typedef struct packed {
    logic       k;
    logic [7:0] d;
  } sym_t;

  // Transmit engine states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;
endpackage : isf_pkg
`default_nettype wire

// [rtl/inband_status_message_framer.sv]
// In-band status message framer: builds and parses short link control messages
`default_nettype none

// Behaviour
// - K28.1 first, CRC-8 last, K excluded
// - response control byte: ack, direction, address
// - response data MSB, LSB, zero, CRC
// - send status on change or period
// - resend status when retry timeout expires
// - status control byte 0x80
// - first status byte: wake, idle, backpressure, low-power
// - reset complete bit 7, bit 6 zero
// - serial link, disconnect, copper link bits
// - bit 2 gives duplex mode
// - speed code in bits 1:0
// - only status sent unasked, then await ack
// - interface switch before ack resends status
module inband_status_message_framer (
  input  wire logic          clk_i,        // 50 MHz clock
  input  wire logic          rst_i,        // Synchronous reset, high
  input  wire logic [3:0]    wb_adr_i,     // Byte address
  input  wire logic [31:0]   wb_dat_i,     // Write data
  output logic      [31:0]   wb_dat_o,     // Read data
  input  wire logic          wb_we_i,      // Write enable
  input  wire logic [3:0]    wb_sel_i,     // Byte enables
  input  wire logic          wb_cyc_i,     // Cycle
  input  wire logic          wb_stb_i,     // Strobe
  output logic               wb_ack_o,     // Acknowledge
  output isf_pkg::sym_t      tx_sym_o,     // Symbol to serial link
  output logic               tx_valid_o,   // Symbol valid
  input  wire logic          tx_ready_i,   // Link takes symbol
  input  wire isf_pkg::sym_t rx_sym_i,     // Symbol from serial link
  input  wire logic          rx_valid_i,   // Received symbol valid
  input  wire logic          iface_sel_i,  // Active interface select
  output logic      [15:0]   mac_status_o  // Last controller status
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic                ack;
    logic [31:0]         rdat;
    logic [15:0]         stat;
    logic [15:0]         period;
    logic [15:0]         retry;
    logic [15:0]         mac_stat;
    logic [15:0]         sent;
    isf_pkg::tx_state_t  st;
    logic [2:0]          idx;
    logic [7:0]          tcrc;
    logic [7:0]          tctl;
    logic [15:0]         tdat;
    isf_pkg::sym_t       tx;
    logic                tx_vld;
    logic                resp_pend;
    logic [7:0]          resp_ctl;
    logic [15:0]         resp_dat;
    logic                wait_ack;
    logic                stat_pend;
    logic [5:0]          us_cnt;
    logic [15:0]         per_cnt;
    logic [15:0]         rty_cnt;
    logic [2:0]          rcnt;
    logic [7:0]          rcrc;
    logic [23:0]         rbuf;
    logic [7:0]          crc_err;
    logic [1:0]          isync;
    logic                iprev;
  } state_t;

  state_t q;
  state_t d;
  logic [15:0] mdio_mem [32];
  logic        mem_we;
  logic [4:0]  mem_adr;
  logic [15:0] mem_dat;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // CRC-8, polynomial x8+x2+x+1, one byte
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ isf_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Symbol at frame position n
  function automatic isf_pkg::sym_t frame_sym(input logic [2:0] n, input logic [7:0] ctl,
                                              input logic [15:0] dat, input logic [7:0] crc);
    isf_pkg::sym_t s;
    s.k = 1'b0;
    case (n)
      3'h0: begin
        s.k = 1'b1;
        s.d = isf_pkg::K28_1;
      end
      3'h1: s.d = ctl;
      3'h2: s.d = dat[15:8];
      3'h3: s.d = dat[7:0];
      3'h4: s.d = isf_pkg::RSV_BYTE;
      default: s.d = crc;
    endcase
    return s;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic        acc;
    logic        hit;
    logic        tmo;
    logic        tick;
    logic        isw;
    logic        ack_in;
    logic        req_in;
    logic [2:0]  nb;
    d       = q;
    mem_we  = 1'b0;
    mem_adr = q.rbuf[23:19];
    mem_dat = q.rbuf[15:0];
    acc     = 1'b0;
    tmo     = 1'b0;
    isw     = 1'b0;
    ack_in  = 1'b0;
    req_in  = 1'b0;
    nb      = 3'h0;
    hit     = wb_cyc_i && wb_stb_i && !q.ack;
    tick    = (q.us_cnt == isf_pkg::CYC_PER_US - 6'h1);

    // Wishbone slave, one wait state, ack drops after one cycle
    d.ack = hit;
    if (hit) begin
      d.rdat = 32'h0;
      case (wb_adr_i)
        isf_pkg::OFS_STATUS: d.rdat[15:0] = q.stat;
        isf_pkg::OFS_PERIOD: d.rdat[15:0] = q.period;
        isf_pkg::OFS_RETRY:  d.rdat[15:0] = q.retry;
        isf_pkg::OFS_INFO:   d.rdat = {q.wait_ack, 7'h0, q.crc_err, q.mac_stat};
        default:             d.rdat = 32'h0;
      endcase
      if (wb_we_i) begin
        for (int b = 0; b < 2; b++) begin
          if (wb_sel_i[b]) begin
            case (wb_adr_i)
              isf_pkg::OFS_STATUS: d.stat[b*8 +: 8] = wb_dat_i[b*8 +: 8] & isf_pkg::STAT_MASK[b*8 +: 8];
              isf_pkg::OFS_PERIOD: d.period[b*8 +: 8] = wb_dat_i[b*8 +: 8];
              isf_pkg::OFS_RETRY:  d.retry[b*8 +: 8] = wb_dat_i[b*8 +: 8];
              default: ;
            endcase
          end
        end
      end
    end

    // Microsecond tick for both timeouts
    d.us_cnt = tick ? 6'h0 : q.us_cnt + 6'h1;

    if (q.period == 16'h0) begin
      d.per_cnt = 16'h0;
    end else if (tick) begin
      d.per_cnt = q.per_cnt + 16'h1;
      if (q.per_cnt + 16'h1 >= q.period) begin
        d.per_cnt = 16'h0;
        d.stat_pend = 1'b1;
      end
    end
    if (q.stat != q.sent) begin
      d.stat_pend = 1'b1;
    end

    // retry timer runs while awaiting ack with the engine idle
    if (q.wait_ack && q.st == isf_pkg::TX_IDLE) begin
      if (tick) begin
        d.rty_cnt = q.rty_cnt + 16'h1;
        tmo = (q.rty_cnt + 16'h1 >= q.retry);
      end
    end else begin
      d.rty_cnt = 16'h0;
    end

    // Interface select synchroniser, edge from second stage only
    d.isync = {q.isync[0], iface_sel_i};
    d.iprev = q.isync[1];
    isw = q.isync[1] ^ q.iprev;

    if (rx_valid_i) begin
      if (rx_sym_i.k) begin
        d.rcnt = (rx_sym_i.d == isf_pkg::K28_1) ? 3'h1 : 3'h0;
        d.rcrc = 8'h00;
      end else if (q.rcnt != 3'h0 && q.rcnt != isf_pkg::LAST_IDX) begin
        d.rbuf = (q.rcnt == isf_pkg::LAST_IDX - 3'h1) ? q.rbuf : {q.rbuf[15:0], rx_sym_i.d}; // Byte four only in CRC
        d.rcrc = crc8(q.rcrc, rx_sym_i.d);
        d.rcnt = q.rcnt + 3'h1;
      end else if (q.rcnt == isf_pkg::LAST_IDX) begin
        d.rcnt = 3'h0;
        if (rx_sym_i.d != q.rcrc) begin
          d.crc_err = q.crc_err + 8'h1;
        end else if (q.rbuf[23:22] == 2'b00) begin
          // request parsed as control and data, device byte ignored
          // one response, same address and direction
          d.resp_pend = 1'b1;
          d.resp_ctl = isf_pkg::CTL_RESP | {2'b00, q.rbuf[16 + isf_pkg::CTL_WR_BIT], 5'h00} | {3'b000, q.rbuf[20:16]};
          req_in = 1'b1;
          mem_adr = q.rbuf[20:16];
          mem_we = q.rbuf[16 + isf_pkg::CTL_WR_BIT];
          d.resp_dat = mem_we ? q.rbuf[15:0] : mdio_mem[q.rbuf[20:16]];
        end else if (q.rbuf[23:16] == isf_pkg::CTL_ACK) begin
          // ack fields are not acted upon
          ack_in = 1'b1;
        end else if (q.rbuf[23:16] == isf_pkg::CTL_STATUS) begin
          d.mac_stat = q.rbuf[15:0];
        end
      end
    end

    // ack clears the wait, set by sending wins
    if (ack_in) begin
      d.wait_ack = 1'b0;
    end
    if (q.wait_ack && (tmo || isw)) begin
      d.stat_pend = 1'b1;
    end

    // Transmit engine
    case (q.st)
      isf_pkg::TX_IDLE: begin
        if (q.resp_pend) begin
          d.resp_pend = req_in;
          d.tctl = q.resp_ctl;
          d.tdat = q.resp_dat;
          acc = 1'b1;
        end else if (q.stat_pend || d.stat_pend) begin
          d.stat_pend = 1'b0;
          d.tctl = isf_pkg::CTL_STATUS;
          d.tdat = q.stat & isf_pkg::STAT_MASK;
          d.sent = q.stat;
          d.wait_ack = 1'b1;
          acc = 1'b1;
        end
        if (acc) begin
          d.st = isf_pkg::TX_SEND;
          d.idx = 3'h0;
          d.tcrc = 8'h00;
          d.tx = frame_sym(3'h0, 8'h00, 16'h0, 8'h00);
          d.tx_vld = 1'b1;
        end
      end
      isf_pkg::TX_SEND: begin
        if (tx_ready_i) begin
          if (q.idx == isf_pkg::LAST_IDX) begin
            d.st = isf_pkg::TX_IDLE;
            d.tx_vld = 1'b0;
          end else begin
            nb = q.idx + 3'h1;
            d.tx = frame_sym(nb, q.tctl, q.tdat, q.tcrc);
            // CRC over bytes after the K symbol
            if (nb != isf_pkg::LAST_IDX) begin
              d.tcrc = crc8(q.tcrc, d.tx.d);
            end
            d.idx = nb;
          end
        end
      end
      default: begin
        d.st = isf_pkg::TX_IDLE;
        d.tx_vld = 1'b0;
      end
    endcase

    if (rst_i) begin
      d = '0;
      d.st = isf_pkg::TX_IDLE;
      d.stat = isf_pkg::RST_STATUS;
      d.sent = isf_pkg::RST_STATUS;
      d.period = isf_pkg::RST_PERIOD;
      d.retry = isf_pkg::RST_RETRY;
      mem_we = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // State register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // Management register array, written by accepted write requests
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mdio_mem[mem_adr] <= mem_dat;
    end
  end

  // Outputs straight from state
  assign wb_ack_o     = q.ack;
  assign wb_dat_o     = q.rdat;
  assign tx_sym_o     = q.tx;
  assign tx_valid_o   = q.tx_vld;
  assign mac_status_o = q.mac_stat;

endmodule // inband_status_message_framer
`default_nettype wire

// [testbench/isf_chk.sv]
// Checker: framing and handshake properties of the framer
`default_nettype none
module isf_chk (
  input wire logic          clk_i,      // Clock
  input wire logic          rst_i,      // Reset
  input wire logic          wb_cyc_i,   // Cycle
  input wire logic          wb_stb_i,   // Strobe
  input wire logic          wb_ack_o,   // Acknowledge
  input wire isf_pkg::sym_t tx_sym_o,   // Symbol out
  input wire logic          tx_valid_o, // Symbol valid
  input wire logic          tx_ready_i  // Symbol taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idx_q;  // Symbol index in frame
  logic       stat_q; // Frame is a status message
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Track symbol position and frame kind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q  <= 3'h0;
      stat_q <= 1'h0;
    end else if (tx_valid_o && tx_ready_i) begin
      idx_q <= (idx_q == isf_pkg::LAST_IDX) ? 3'h0 : idx_q + 3'h1;
      if (idx_q == 3'h1) begin
        stat_q <= (tx_sym_o.d == isf_pkg::CTL_STATUS);
      end
    end
  end
  // Bus answer one cycle after request
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  // Symbol held until taken
  AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_sym_o))
    else $error("symbol dropped before taken");
  AST_K_FIRST: assert property (tx_valid_o && idx_q == 3'h0 |-> tx_sym_o.k && tx_sym_o.d == isf_pkg::K28_1)
    else $error("frame lacks start symbol");
  AST_NO_K: assert property (tx_valid_o && idx_q != 3'h0 |-> !tx_sym_o.k)
    else $error("control symbol inside frame");
  AST_GAP: assert property (tx_valid_o && tx_ready_i && idx_q == isf_pkg::LAST_IDX |=> !tx_valid_o)
    else $error("no idle after frame");
  AST_CTL: assert property (tx_valid_o && idx_q == 3'h1 |-> tx_sym_o.d[7:6] == 2'h1 || tx_sym_o.d == 8'h80)
    else $error("bad control byte");
  AST_STAT1: assert property (tx_valid_o && idx_q == 3'h2 && stat_q |-> (tx_sym_o.d & 8'hd8) == 8'h00)
    else $error("reserved status bits set");
  AST_RSV: assert property (tx_valid_o && idx_q == 3'h4 |-> tx_sym_o.d == isf_pkg::RSV_BYTE)
    else $error("reserved byte not zero");
  // Main scenarios reached
  cover property (tx_valid_o && !tx_ready_i);
  cover property (tx_valid_o && idx_q == 3'h1 && stat_q);
  cover property (wb_ack_o);
endmodule // isf_chk
bind inband_status_message_framer isf_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_sym_o,
  .tx_valid_o, .tx_ready_i);
`default_nettype wire

// [testbench/mac_model.sv]
// Partner model: controller side of the serial link
`default_nettype none
module mac_model (
  input  wire logic          clk_i,      // Clock
  input  wire logic          slow_i,     // Stall every other cycle
  input  wire isf_pkg::sym_t tx_sym_i,   // Symbol from framer
  input  wire logic          tx_valid_i, // Symbol valid
  output var logic           tx_ready_o, // Symbol taken
  output isf_pkg::sym_t      rx_sym_o,   // Symbol to framer
  output var logic           rx_valid_o  // Symbol valid
);
  timeunit 1ns;
  timeprecision 1ps;
  isf_pkg::sym_t got[$];   // Symbols taken from framer
  isf_pkg::sym_t out_q[$]; // Symbols waiting to go
  ////////////////////////////////////////
  // CRC-8, poly x8+x2+x+1, zero start, msb first
  function automatic logic [7:0] crc8(input logic [31:0] b);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'h0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic send(input logic [31:0] b, input logic bad);
    out_q.push_back({1'h1, isf_pkg::K28_1});
    for (int i = 3; i >= 0; i--) begin
      out_q.push_back({1'h0, b[8 * i +: 8]});
    end
    out_q.push_back({1'h0, crc8(b) ^ {7'h00, bad}});
  endtask
  // Take symbols, send queued ones, scramble idle line
  always @(posedge clk_i) begin
    tx_ready_o <= !slow_i || !tx_ready_o;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_sym_i);
    end
    if (out_q.size() > 0) begin
      rx_valid_o <= 1'h1;
      rx_sym_o   <= out_q.pop_front();
    end else begin
      rx_valid_o <= 1'h0;
      rx_sym_o   <= ~rx_sym_o;
    end
  end
  // Start values
  initial begin
    tx_ready_o = 1'h0;
    rx_valid_o = 1'h0;
    rx_sym_o   = 9'h0;
  end
endmodule // mac_model
`default_nettype wire

// [testbench/tb.sv]
// Testbench: bus, link and timeout scenarios for the framer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_i = 1'h0, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic          tx_valid_o, tx_ready_i, rx_valid_i, iface_sel_i, slow;
  logic [3:0]    wb_adr_i;
  logic [31:0]   wb_dat_i, wb_dat_o;
  logic [15:0]   mac_status_o;
  isf_pkg::sym_t tx_sym_o, rx_sym_i;
  int            err_count = 0, check_count = 0;
  localparam logic [31:0] ST1 = {isf_pkg::CTL_STATUS, 16'h0001, 8'h00};
  localparam logic [31:0] ACK = {isf_pkg::CTL_ACK, 8'h10, 16'h0000};
  ////////////////////////////////////////
  inband_status_message_framer i_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i(4'hf), .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_sym_o, .tx_valid_o, .tx_ready_i, .rx_sym_i,
    .rx_valid_i, .iface_sel_i, .mac_status_o);
  mac_model i_mac (.clk_i, .slow_i(slow), .tx_sym_i(tx_sym_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .rx_sym_o(rx_sym_i), .rx_valid_o(rx_valid_i));
  // Clock
  always #10 clk_i = ~clk_i;
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One classic bus cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'h0, a, 32'h0, r);
    check(r, e);
  endtask
  // Compare next six link symbols with a frame
  task automatic frame(input logic [31:0] b);
    int n;
    logic [8:0] s, e;
    n = 0;
    while (i_mac.got.size() < 6 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    for (int i = 0; i < 6; i++) begin
      s = (i_mac.got.size() > 0) ? i_mac.got.pop_front() : 9'h0;
      e = (i == 0) ? {1'h1, isf_pkg::K28_1} : {1'h0, (i == 5) ? i_mac.crc8(b) : b[39 - 8 * i -: 8]};
      check({23'h0, s}, {23'h0, e});
    end
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge clk_i);
    check(32'(i_mac.got.size()), 32'h0);
  endtask
  task automatic t_regs();
    rd(isf_pkg::OFS_RETRY, {16'h0, isf_pkg::RST_RETRY});
    rd(isf_pkg::OFS_PERIOD, {16'h0, isf_pkg::RST_PERIOD});
    wr(4'h2, 32'hffff);
    rd(4'h2, 32'h0);
    wr(isf_pkg::OFS_RETRY, 32'h2);
  endtask
  task automatic t_status();
    wr(isf_pkg::OFS_STATUS, 32'hfffe);
    frame({isf_pkg::CTL_STATUS, 16'hfffe & isf_pkg::STAT_MASK, 8'h00});
    rd(isf_pkg::OFS_INFO, 32'h80000000);
    frame({isf_pkg::CTL_STATUS, 16'hfffe & isf_pkg::STAT_MASK, 8'h00});
    i_mac.send(ACK, 1'h0);
    repeat (12) @(posedge clk_i);
    rd(isf_pkg::OFS_INFO, 32'h0);
    quiet(300);
  endtask
  task automatic t_req();
    i_mac.send({8'h25, 16'h1234, 8'h01}, 1'h0);
    frame({8'h65, 16'h1234, 8'h00});
    slow <= 1'h1;
    i_mac.send({8'h05, 16'h0000, 8'h01}, 1'h0);
    frame({8'h45, 16'h1234, 8'h00});
    slow <= 1'h0;
  endtask
  task automatic t_bad();
    i_mac.send({8'h25, 16'h5678, 8'h01}, 1'h1);
    quiet(50);
    rd(isf_pkg::OFS_INFO, 32'h00010000);
    i_mac.send({8'h05, 16'h0000, 8'h01}, 1'h0);
    frame({8'h45, 16'h1234, 8'h00});
    i_mac.send({isf_pkg::CTL_STATUS, 16'h0ff5, 8'h00}, 1'h0);
    repeat (12) @(posedge clk_i);
    check({16'h0, mac_status_o}, 32'h0ff5);
  endtask
  task automatic t_iface();
    wr(isf_pkg::OFS_RETRY, 32'h64);
    wr(isf_pkg::OFS_STATUS, 32'h0001);
    frame(ST1);
    iface_sel_i <= 1'h1;
    frame(ST1);
    i_mac.send(ACK, 1'h0);
    repeat (12) @(posedge clk_i);
    wr(isf_pkg::OFS_PERIOD, 32'h2);
    frame(ST1);
    wr(isf_pkg::OFS_PERIOD, 32'h0);
  endtask
  // Reset, scenarios, verdict
  initial begin
    rst_i       = 1'h1;
    wb_cyc_i    = 1'h0;
    wb_stb_i    = 1'h0;
    wb_we_i     = 1'h0;
    wb_adr_i    = 4'h0;
    wb_dat_i    = 32'h0;
    iface_sel_i = 1'h0;
    slow        = 1'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_regs();
    t_status();
    t_req();
    t_bad();
    t_iface();
    give_verdict();
  end
  // Watchdog
  initial begin
    #1000000;
    err_count++;
    give_verdict();
  end
endmodule // tb
`default_nettype wire
